// *** verilog/usl_top.sv ***
`timescale 1ns/1ns
module usl_top #(
  // Arbitrary code values
  parameter logic [7:0] REV_CODE = 8'h5A,
  parameter logic [7:0] ID_CODE  = 8'hC3
) (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  input  wire logic [2:0]      addr,
  input  wire logic [7:0]      data_in,
  input  wire logic            channel_one_select_n,
  input  wire logic            channel_two_select_n,
  input  wire logic            read_strobe_n,
  input  wire logic            write_strobe_n,
  input  wire logic            bus_isolate_pin,
  input  wire logic [1:0]      rx_pin,
  input  wire logic [1:0]      cts_pin_n,
  input  wire logic [1:0]      dsr_pin_n,
  input  wire logic [1:0]      cd_pin_n,
  input  wire logic [1:0]      ri_pin_n,
  input  wire logic [1:0]      core_tx_bit,
  input  wire logic [1:0]      core_rts_req,
  input  wire logic [1:0]      core_int,
  input  wire logic [1:0][7:0] core_isr,
  input  wire logic [1:0][7:0] core_rx_byte,
  input  wire logic [1:0][7:0] core_line_status,
  output logic [7:0]           data_out,
  output logic                 data_oe,
  output logic [1:0]           tx_pin,
  output logic [1:0]           rts_pin_n,
  output logic [1:0]           dtr_pin_n,
  output logic                 oscillator_output_pin,
  output logic                 sleeping,
  output logic [1:0]           irq,
  output logic [1:0]           core_rx_bit,
  output logic [1:0]           cts_hold,
  output logic [1:0]           tx_load,
  output logic [1:0]           rx_pop,
  output logic [1:0]           fifo_load,
  output logic [7:0]           load_byte,
  output logic [1:0][7:0]      divisor_low,
  output logic [1:0][7:0]      divisor_high,
  output logic [1:0][7:0]      divisor_fraction,
  output logic [1:0][7:0]      line_control,
  output logic [1:0][7:0]      enhanced_function
);

  logic [usl_pkg::PIN_W-1:0] pin_s1;
  logic [usl_pkg::PIN_W-1:0] pin_s2;
  logic [2:0]                a_addr;
  logic [7:0]                a_data;
  logic                      a_cs2_n;
  logic                      a_cs1_n;
  logic                      a_rd_n;
  logic                      a_wr_n;
  logic                      a_iso;
  logic [1:0]                a_rx;
  logic [1:0]                a_cts;
  logic [1:0]                a_dsr;
  logic [1:0]                a_cd;
  logic [1:0]                a_ri;
  usl_pkg::usl_power_t       pwr_state;
  usl_pkg::usl_power_t       next_state;
  logic [1:0][7:0]           modem_control;
  logic [1:0][7:0]           interrupt_enable;
  logic [1:0][7:0]           scratch_pad;
  logic [1:0][3:0][7:0]      flow_char;
  logic [1:0][3:0]           delta;
  logic [1:0][3:0]           mdm;
  logic [1:0][3:0]           mdm_prev;
  logic [1:0][7:0]           rd_val;
  logic [1:0][7:0]           isr_val;
  logic [1:0]                wake;
  logic [1:0]                rx_prev;
  logic                      rd_prev;
  logic                      wr_prev;
  logic                      isolated;
  logic                      rd_go;
  logic                      wr_go;
  logic [1:0]                sel;
  logic [1:0]                rd_ch;
  logic [1:0]                wr_ch;
  logic [1:0]                dlab;
  logic [1:0]                enh;
  logic [1:0]                frac_ok;
  logic [1:0]                divz;
  logic [1:0]                lb;
  logic [1:0]                pend;
  logic [1:0]                thr_wr;
  logic [1:0]                isr_rd;
  logic [1:0]                msr_rd;
  logic                      both_en;
  logic                      ready;
  logic                      mdm_chg;
  logic                      wake_ev;

  // Every pin passes two flip-flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
    end else if (clk_en) begin
      pin_s1 <= {addr, data_in, channel_two_select_n,
                 channel_one_select_n, read_strobe_n, write_strobe_n,
                 bus_isolate_pin, rx_pin, cts_pin_n, dsr_pin_n,
                 cd_pin_n, ri_pin_n};
      pin_s2 <= pin_s1;
    end
  end

  assign {a_addr, a_data, a_cs2_n, a_cs1_n, a_rd_n, a_wr_n, a_iso,
          a_rx, a_cts, a_dsr, a_cd, a_ri} = pin_s2;

  // Bus inputs are dead while isolated
  assign isolated = (pwr_state == usl_pkg::USL_ASLEEP) && a_iso;
  assign rd_go = rd_prev && !a_rd_n && !isolated;
  assign wr_go = !wr_prev && a_wr_n && !isolated;
  assign sel = {!a_cs2_n, !a_cs1_n} & {2{!isolated}};
  assign rd_ch = sel & {2{rd_go}};
  assign wr_ch = sel & {2{wr_go}};
  assign both_en = interrupt_enable[0][usl_pkg::IENA_SLEEP]
                && interrupt_enable[1][usl_pkg::IENA_SLEEP];

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      dlab[c] = line_control[c][usl_pkg::LCTL_DIV];
      enh[c] = line_control[c] == usl_pkg::LCTL_ENH;
      frac_ok[c] = dlab[c] && !enh[c]
                && enhanced_function[c][usl_pkg::EFR_ENH];
      divz[c] = divisor_low[c] == usl_pkg::DIV_ZERO
             && divisor_high[c] == usl_pkg::DIV_ZERO;
      lb[c] = modem_control[c][usl_pkg::MCTL_LOOP];
      // Loopback feeds modem status from modem control
      if (lb[c]) begin
        mdm[c] = {modem_control[c][usl_pkg::MCTL_OP2],
                  modem_control[c][usl_pkg::MCTL_OP1],
                  modem_control[c][usl_pkg::MCTL_DTR],
                  modem_control[c][usl_pkg::MCTL_RTS]};
      end else begin
        mdm[c] = ~{a_cd[c], a_ri[c], a_dsr[c], a_cts[c]};
      end
      pend[c] = wake[c] || core_int[c] || (|delta[c]
             && interrupt_enable[c][usl_pkg::IENA_MODEM]);
      isr_val[c][7:4] = core_isr[c][7:4];
      if (core_int[c]) begin
        isr_val[c][3:0] = core_isr[c][3:0];
      end else if (|delta[c]
                   && interrupt_enable[c][usl_pkg::IENA_MODEM]) begin
        isr_val[c][3:0] = usl_pkg::ISR_MODEM;
      end else begin
        isr_val[c][3:0] = usl_pkg::ISR_IDLE;
      end
      thr_wr[c] = wr_ch[c] && a_addr == usl_pkg::ADR_HOLD
               && !dlab[c];
      isr_rd[c] = rd_ch[c] && a_addr == usl_pkg::ADR_ISTAT
               && !enh[c] && !frac_ok[c];
      msr_rd[c] = rd_ch[c] && a_addr == usl_pkg::ADR_MSTAT
               && !enh[c];
    end
  end

  // Read data selection per channel
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      case (a_addr)
        usl_pkg::ADR_HOLD: begin
          if (!dlab[c]) rd_val[c] = core_rx_byte[c];
          else if (enh[c]) rd_val[c] = usl_pkg::REG_RESET;
          else if (divz[c]) rd_val[c] = REV_CODE;
          else rd_val[c] = divisor_low[c];
        end
        usl_pkg::ADR_IENA: begin
          if (!dlab[c]) rd_val[c] = interrupt_enable[c];
          else if (enh[c]) rd_val[c] = usl_pkg::REG_RESET;
          else if (divz[c]) rd_val[c] = ID_CODE;
          else rd_val[c] = divisor_high[c];
        end
        usl_pkg::ADR_ISTAT: begin
          if (enh[c]) rd_val[c] = enhanced_function[c];
          else if (frac_ok[c]) rd_val[c] = divisor_fraction[c];
          else rd_val[c] = isr_val[c];
        end
        usl_pkg::ADR_LCTL: begin
          rd_val[c] = line_control[c];
        end
        default: begin
          if (enh[c]) rd_val[c] = flow_char[c][a_addr[1:0]];
          else if (a_addr == usl_pkg::ADR_MCTL)
            rd_val[c] = modem_control[c];
          else if (a_addr == usl_pkg::ADR_LSTAT)
            rd_val[c] = core_line_status[c];
          else if (a_addr == usl_pkg::ADR_MSTAT)
            rd_val[c] = {mdm[c], delta[c]};
          else rd_val[c] = scratch_pad[c];
        end
      endcase
    end
  end

  // Register writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor_low <= {2{usl_pkg::REG_RESET}};
      divisor_high <= {2{usl_pkg::REG_RESET}};
      divisor_fraction <= {2{usl_pkg::REG_RESET}};
      line_control <= {2{usl_pkg::REG_RESET}};
      enhanced_function <= {2{usl_pkg::REG_RESET}};
      modem_control <= {2{usl_pkg::REG_RESET}};
      interrupt_enable <= {2{usl_pkg::REG_RESET}};
      scratch_pad <= {2{usl_pkg::REG_RESET}};
      flow_char <= {8{usl_pkg::REG_RESET}};
    end else if (clk_en) begin
      for (int c = 0; c < 2; c++) begin
        if (wr_ch[c]) begin
          case (a_addr)
            usl_pkg::ADR_HOLD: begin
              if (dlab[c] && !enh[c]) divisor_low[c] <= a_data;
            end
            usl_pkg::ADR_IENA: begin
              if (!dlab[c]) begin
                if (enhanced_function[c][usl_pkg::EFR_ENH])
                  interrupt_enable[c] <= a_data;
                else
                  interrupt_enable[c] <= a_data & usl_pkg::IENA_BASE;
              end else if (!enh[c]) begin
                divisor_high[c] <= a_data;
              end
            end
            usl_pkg::ADR_ISTAT: begin
              if (enh[c]) enhanced_function[c] <= a_data;
              else if (frac_ok[c])
                divisor_fraction[c] <= a_data & usl_pkg::FRAC_MASK;
            end
            usl_pkg::ADR_LCTL: begin
              line_control[c] <= a_data;
            end
            default: begin
              if (enh[c]) flow_char[c][a_addr[1:0]] <= a_data;
              else if (a_addr == usl_pkg::ADR_MCTL)
                modem_control[c] <= a_data;
              else if (a_addr == usl_pkg::ADR_SCRATCH)
                scratch_pad[c] <= a_data;
            end
          endcase
        end
      end
    end
  end

  // Strobes handed to the channel cores
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_load <= '0;
      rx_pop <= '0;
      fifo_load <= '0;
      load_byte <= usl_pkg::REG_RESET;
    end else if (clk_en) begin
      for (int c = 0; c < 2; c++) begin
        tx_load[c] <= thr_wr[c];
        rx_pop[c] <= rd_ch[c] && a_addr == usl_pkg::ADR_HOLD
                  && !dlab[c];
        fifo_load[c] <= wr_ch[c] && a_addr == usl_pkg::ADR_ISTAT
                     && !enh[c] && !frac_ok[c];
      end
      if (wr_go) load_byte <= a_data;
    end
  end

  // Modem change flags, set wins over read clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdm_prev <= '0;
      delta <= '0;
      rx_prev <= '1;
    end else if (clk_en) begin
      mdm_prev <= mdm;
      rx_prev <= a_rx;
      for (int c = 0; c < 2; c++) begin
        delta[c] <= (delta[c] & {4{!msr_rd[c]}})
                 | (mdm[c] ^ mdm_prev[c]);
      end
    end
  end

  assign mdm_chg = |(mdm ^ mdm_prev);
  assign wake_ev = |(rx_prev & ~a_rx) || mdm_chg || |thr_wr;
  assign ready = !(|pend) && both_en && !(|delta) && &a_rx;

  always_comb begin
    next_state = pwr_state;
    case (pwr_state)
      usl_pkg::USL_AWAKE: begin
        if (ready && !wake_ev) next_state = usl_pkg::USL_ASLEEP;
      end
      usl_pkg::USL_ASLEEP: begin
        if (wake_ev || !both_en) next_state = usl_pkg::USL_AWAKE;
      end
      default: begin
        next_state = usl_pkg::USL_AWAKE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state <= usl_pkg::USL_AWAKE;
      sleeping <= 1'b0;
    end else if (clk_en) begin
      pwr_state <= next_state;
      sleeping <= next_state == usl_pkg::USL_ASLEEP;
    end
  end

  // Wake indication, set wins over status read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake <= '0;
    end else if (clk_en) begin
      for (int c = 0; c < 2; c++) begin
        wake[c] <= (pwr_state == usl_pkg::USL_ASLEEP && wake_ev
                    && interrupt_enable[c][usl_pkg::IENA_SLEEP])
                || (wake[c] && !isr_rd[c]);
      end
    end
  end

  // Serial and modem pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin <= '1;
      rts_pin_n <= '1;
      dtr_pin_n <= '1;
      core_rx_bit <= '1;
      cts_hold <= '0;
      irq <= '0;
    end else if (clk_en) begin
      for (int c = 0; c < 2; c++) begin
        core_rx_bit[c] <= lb[c] ? core_tx_bit[c] : a_rx[c];
        tx_pin[c] <= lb[c] || core_tx_bit[c];
        if (lb[c]) begin
          rts_pin_n[c] <= 1'b1;
        end else if (enhanced_function[c][usl_pkg::EFR_ARTS]) begin
          rts_pin_n[c] <= !core_rts_req[c];
        end else begin
          rts_pin_n[c] <= !modem_control[c][usl_pkg::MCTL_RTS];
        end
        dtr_pin_n[c] <= lb[c]
                     || !modem_control[c][usl_pkg::MCTL_DTR];
        cts_hold[c] <= enhanced_function[c][usl_pkg::EFR_ACTS]
                    && !lb[c] && a_cts[c];
        irq[c] <= pend[c];
      end
    end
  end

  // Clock output dies in sleep
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_output_pin <= 1'b0;
    end else if (clk_en) begin
      oscillator_output_pin <= (pwr_state == usl_pkg::USL_AWAKE)
                            && !oscillator_output_pin;
    end
  end

  // Parallel bus read side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
      data_out <= usl_pkg::REG_RESET;
      data_oe <= 1'b0;
    end else if (clk_en) begin
      rd_prev <= a_rd_n;
      wr_prev <= a_wr_n;
      data_oe <= !a_rd_n && |sel;
      if (rd_ch[0]) data_out <= rd_val[0];
      else if (rd_ch[1]) data_out <= rd_val[1];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wake_asleep;
    pwr_state == usl_pkg::USL_ASLEEP && wake_ev && both_en && clk_en;
  endsequence

  sequence s_rev_read;
    rd_ch[0] && a_addr == usl_pkg::ADR_HOLD && dlab[0] && !enh[0]
    && divz[0] && clk_en;
  endsequence

  property p_sleep_entry;
    $rose(sleeping) |-> $past(ready) && !$past(|pend);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entered without its conditions");

  property p_osc_stop;
    pwr_state == usl_pkg::USL_ASLEEP && clk_en
      |=> !oscillator_output_pin;
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("clock output toggles in sleep");

  property p_wake;
    s_wake_asleep |=> pwr_state == usl_pkg::USL_AWAKE && wake[0]
      && wake[1];
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake event did not wake the device");

  property p_wake_clear;
    wake[0] && isr_rd[0] && clk_en
      && pwr_state == usl_pkg::USL_AWAKE |=> !wake[0];
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("status read did not clear wake flag");

  property p_no_sleep_pending;
    pwr_state == usl_pkg::USL_AWAKE && |pend && clk_en
      |=> pwr_state == usl_pkg::USL_AWAKE;
  endproperty
  a_no_sleep_pending: assert property (p_no_sleep_pending)
    else $error("sleep entered with interrupt pending");

  property p_sleep_holds;
    pwr_state == usl_pkg::USL_ASLEEP && !wake_ev && both_en && clk_en
      |=> pwr_state == usl_pkg::USL_ASLEEP;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds)
    else $error("sleep left without cause");

  property p_isolate_block;
    isolated && clk_en |=> tx_load == 2'b00 && fifo_load == 2'b00;
  endproperty
  a_isolate_block: assert property (p_isolate_block)
    else $error("bus write passed while isolated");

  property p_loop_pins;
    lb[0] && clk_en |=> tx_pin[0] && rts_pin_n[0] && dtr_pin_n[0];
  endproperty
  a_loop_pins: assert property (p_loop_pins)
    else $error("loopback pins not held");

  property p_loop_data;
    lb[0] && clk_en |=> core_rx_bit[0] == $past(core_tx_bit[0]);
  endproperty
  a_loop_data: assert property (p_loop_data)
    else $error("loopback data not returned");

  property p_loop_cts;
    lb[0] && clk_en |=> !cts_hold[0];
  endproperty
  a_loop_cts: assert property (p_loop_cts)
    else $error("auto flow active in loopback");

  property p_rev_read;
    s_rev_read |=> data_out == REV_CODE;
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("revision code not returned");

endmodule

// *** verilog/usl_pkg.sv ***
package usl_pkg;
  typedef enum logic {USL_AWAKE, USL_ASLEEP} usl_power_t;
  localparam logic [2:0] ADR_HOLD    = 3'h0;
  localparam logic [2:0] ADR_IENA    = 3'h1;
  localparam logic [2:0] ADR_ISTAT   = 3'h2;
  localparam logic [2:0] ADR_LCTL    = 3'h3;
  localparam logic [2:0] ADR_MCTL    = 3'h4;
  localparam logic [2:0] ADR_LSTAT   = 3'h5;
  localparam logic [2:0] ADR_MSTAT   = 3'h6;
  localparam logic [2:0] ADR_SCRATCH = 3'h7;
  localparam logic [7:0] LCTL_ENH    = 8'hBF;
  localparam logic [7:0] DIV_ZERO    = 8'h00;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] IENA_BASE   = 8'h0F;
  localparam logic [7:0] FRAC_MASK   = 8'h3F;
  localparam logic [3:0] ISR_IDLE    = 4'h1;
  localparam logic [3:0] ISR_MODEM   = 4'h0;
  localparam int LCTL_DIV   = 7;
  localparam int IENA_MODEM = 3;
  localparam int IENA_SLEEP = 4;
  localparam int MCTL_DTR   = 0;
  localparam int MCTL_RTS   = 1;
  localparam int MCTL_OP1   = 2;
  localparam int MCTL_OP2   = 3;
  localparam int MCTL_LOOP  = 4;
  localparam int EFR_ENH    = 4;
  localparam int EFR_ARTS   = 6;
  localparam int EFR_ACTS   = 7;
  localparam int PIN_W      = 26;
endpackage

// *** verification/usl_remote.sv ***
`timescale 1ns/1ns
module usl_remote (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] start_req,
  input  wire logic [1:0] flip_req,
  output logic [1:0]      rx_pin,
  output logic [1:0]      cts_pin_n,
  output logic [1:0]      dsr_pin_n,
  output logic [1:0]      cd_pin_n,
  output logic [1:0]      ri_pin_n
);
  logic [1:0][3:0] low_cnt;

  // Pulled-up lines rest high
  assign dsr_pin_n = 2'h3;
  assign cd_pin_n  = 2'h3;
  assign ri_pin_n  = 2'h3;

  // Short start bit, then the line marks again
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt   <= '0;
      rx_pin    <= 2'h3;
      cts_pin_n <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (start_req[i]) begin
          low_cnt[i] <= 4'h8;
        end else if (low_cnt[i] != 4'h0) begin
          low_cnt[i] <= low_cnt[i] - 4'h1;
        end
        rx_pin[i] <= !start_req[i] && (low_cnt[i] <= 4'h1);
        if (flip_req[i]) begin
          cts_pin_n[i] <= !cts_pin_n[i];
        end
      end
    end
  end
endmodule

// *** verification/tb_usl_top.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_usl_top;
  localparam logic [7:0] REV = 8'h3C;  // Arbitrary
  localparam logic [7:0] IDC = 8'h96;  // Arbitrary
  int fail_count = 0;
  int checks = 0;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] data_in = 8'h00;
  logic sel1_n = 1'b1;
  logic sel2_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic iso = 1'b0;
  logic [1:0] start_req = 2'h0;
  logic [1:0] flip_req = 2'h0;
  logic [1:0] core_tx_bit = 2'h3;
  logic [1:0] core_rts_req = 2'h0;
  logic [1:0] core_int = 2'h0;
  logic [1:0][7:0] core_isr = '0;
  logic [1:0][7:0] core_rx_byte = '0;
  logic [1:0][7:0] core_line_status = '0;
  logic [1:0] rx_pin, cts_pin_n, dsr_pin_n, cd_pin_n, ri_pin_n;
  logic [1:0] tx_pin, rts_pin_n, dtr_pin_n, irq, core_rx_bit, cts_hold;
  logic [7:0] data_out, load_byte, v, r, s, dl, dh;
  logic data_oe, oscillator_output_pin, sleeping, oe;
  logic [1:0][7:0] divisor_low, line_control, enhanced_function;

  always #10 core_clk = !core_clk;

  usl_remote i_usl_remote (.core_clk, .rst_n, .start_req, .flip_req,
    .rx_pin, .cts_pin_n, .dsr_pin_n, .cd_pin_n, .ri_pin_n);

  usl_top #(.REV_CODE(REV), .ID_CODE(IDC)) i_usl_top (.core_clk, .rst_n,
    .clk_en(1'b1), .addr, .data_in, .channel_one_select_n(sel1_n),
    .channel_two_select_n(sel2_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .bus_isolate_pin(iso), .rx_pin, .cts_pin_n,
    .dsr_pin_n, .cd_pin_n, .ri_pin_n, .core_tx_bit, .core_rts_req,
    .core_int, .core_isr, .core_rx_byte, .core_line_status, .data_out,
    .data_oe, .tx_pin, .rts_pin_n, .dtr_pin_n, .oscillator_output_pin,
    .sleeping, .irq, .core_rx_bit, .cts_hold, .tx_load(), .rx_pop(),
    .fifo_load(), .load_byte, .divisor_low, .divisor_high(),
    .divisor_fraction(), .line_control, .enhanced_function);

  function automatic logic [7:0] div_exp(input bit a, input logic [7:0] l,
                                         input logic [7:0] h);
    if (l == 8'h00 && h == 8'h00) begin
      return a ? IDC : REV;
    end
    return a ? h : l;
  endfunction

  task automatic complete_run();
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic wr(input bit ch, input logic [2:0] a, input logic [7:0] d);
    addr = a;
    data_in = d;
    sel1_n = ch;
    sel2_n = !ch;
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cyc(4);
    sel1_n = 1'b1;
    sel2_n = 1'b1;
    cyc(1);
  endtask

  task automatic rd(input bit ch, input logic [2:0] a);
    addr = a;
    sel1_n = ch;
    sel2_n = !ch;
    rd_n = 1'b0;
    cyc(5);
    v = data_out;
    oe = data_oe;
    rd_n = 1'b1;
    cyc(4);
    sel1_n = 1'b1;
    sel2_n = 1'b1;
    cyc(1);
  endtask

  task automatic rdc(input bit ch, input logic [2:0] a, input logic [7:0] e);
    rd(ch, a);
    `CHK(v, e)
  endtask

  task automatic wait_sleep(input logic st);
    int n;
    n = 0;
    while (sleeping !== st && n < 60) begin
      cyc(1);
      n++;
    end
    `CHK(sleeping, st)
    if (sleeping !== st) begin
      complete_run();
    end
  endtask

  // Service both wake flags
  task automatic svc();
    for (int c = 0; c < 2; c++) begin
      rd(c[0], 3'h2);
      `CHK(v[3:0], 4'h1)
      `CHK(irq[c], 1'b0)
    end
  endtask

  task automatic pulse(input bit ch, input bit flip);
    if (flip) begin
      flip_req[ch] = 1'b1;
    end else begin
      start_req[ch] = 1'b1;
    end
    cyc(1);
    flip_req = 2'h0;
    start_req = 2'h0;
    wait_sleep(1'b0);
    cyc(2);
  endtask

  initial begin
    void'($urandom(60));
    core_rx_byte = {8'($urandom), 8'($urandom)};
    core_line_status = {8'($urandom), 8'($urandom)};
    core_isr = {8'($urandom), 4'($urandom), 4'h6};
    core_rts_req = 2'($urandom);
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
    s = 8'($urandom);
    dl = 8'($urandom) | 8'h01;
    dh = 8'($urandom);
    wr(0, 3'h7, s);
    wr(1, 3'h7, ~s);
    rdc(0, 3'h7, s);
    rdc(1, 3'h7, ~s);
    wr(0, 3'h3, 8'h80);
    wr(0, 3'h0, dl);
    wr(0, 3'h1, dh);
    rdc(0, 3'h0, div_exp(0, dl, dh));
    rdc(0, 3'h1, div_exp(1, dl, dh));
    wr(0, 3'h0, 8'h00);
    wr(0, 3'h1, 8'h00);
    `CHK(divisor_low[0], 8'h00)
    rdc(0, 3'h0, div_exp(0, 8'h00, 8'h00));
    rdc(0, 3'h1, div_exp(1, 8'h00, 8'h00));
    wr(0, 3'h3, usl_pkg::LCTL_ENH);
    wr(0, 3'h2, 8'h90);
    `CHK(enhanced_function[0], 8'h90)
    for (int a = 4; a < 8; a++) begin
      r = 8'($urandom);
      wr(0, 3'(a), r);
      rdc(0, 3'(a), r);
    end
    wr(0, 3'h3, 8'h80);
    wr(0, 3'h2, r);
    rdc(0, 3'h2, r & usl_pkg::FRAC_MASK);
    wr(0, 3'h3, 8'h03);
    rdc(0, 3'h0, core_rx_byte[0]);
    rdc(0, 3'h5, core_line_status[0]);
    rdc(0, 3'h3, 8'h03);
    `CHK(line_control[1], 8'h00)
    // Sleep enable bit is writable only with the enhanced bit set
    wr(1, 3'h3, usl_pkg::LCTL_ENH);
    wr(1, 3'h2, 8'h10);
    wr(1, 3'h3, 8'h00);
    `CHK(enhanced_function[1], 8'h10)
    wr(0, 3'h4, 8'h13);
    `CHK({tx_pin[0], rts_pin_n[0], dtr_pin_n[0]}, 3'h7)
    `CHK(cts_hold[0], 1'b0)
    repeat (6) begin
      core_tx_bit = 2'($urandom);
      cyc(2);
      `CHK(core_rx_bit[0], core_tx_bit[0])
    end
    wr(0, 3'h4, 8'h00);
    `CHK(cts_hold[0], 1'b1)
    rd(0, 3'h6);
    wr(0, 3'h1, 8'h10);
    cyc(10);
    `CHK(sleeping, 1'b0)
    wr(1, 3'h1, 8'h10);
    wait_sleep(1'b1);
    repeat (4) begin
      cyc(1);
      `CHK(oscillator_output_pin, 1'b0)
    end
    pulse(0, 0);
    `CHK(irq, 2'h3)
    svc();
    wait_sleep(1'b1);
    pulse(1, 1);
    svc();
    cyc(10);
    `CHK(sleeping, 1'b0)
    rd(1, 3'h6);
    `CHK(v[0], 1'b1)
    wait_sleep(1'b1);
    r = 8'($urandom);
    wr(0, 3'h0, r);
    wait_sleep(1'b0);
    `CHK(load_byte, r)
    svc();
    wait_sleep(1'b1);
    iso = 1'b1;
    wr(0, 3'h0, ~r);
    cyc(5);
    `CHK(sleeping, 1'b1)
    `CHK(load_byte, r)
    rd(0, 3'h7);
    `CHK(oe, 1'b0)
    pulse(1, 0);
    svc();
    wait_sleep(1'b1);
    rd(0, 3'h7);
    `CHK(oe, 1'b0)
    iso = 1'b0;
    rdc(0, 3'h7, s);
    wr(0, 3'h1, 8'h00);
    wait_sleep(1'b0);
    core_int = 2'h1;
    wr(0, 3'h1, 8'h10);
    cyc(20);
    `CHK(sleeping, 1'b0)
    rd(0, 3'h2);
    `CHK(v[3:0], core_isr[0][3:0])
    `CHK(irq, 2'h1)
    core_int = 2'h0;
    svc();
    wait_sleep(1'b1);
    complete_run();
  end
endmodule
